// File: bench/tlsx_exec_tb_top.sv
// Self-checking bench for the table-latch / skip / xor execution block.
// Assumes results settle one cycle after a take, stores one cycle later.
`timescale 1ns/1ps
module tlsx_exec_tb_top;
	// Stimulus and observed outputs
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic vld = 1'b0;
	logic [15:0] ins = 16'h0000;
	logic [7:0] fd = 8'h00;
	logic busy, squash, zf, zwe;
	tlsx_pkg::tlsx_fwr_t fwr;
	tlsx_pkg::tlsx_pwr_t pwr;
	logic [7:0] wrk;
	logic [15:0] lat, ptr;
	int fails = 0;
	int checks_done = 0;

	// 200 MHz core clock
	always #2.5 clk = ~clk;

	tlsx_exec tlsx_exec_inst (
		.CLK_I(clk),
		.RST_I(rst),
		.INSTR_VALID_I(vld),
		.INSTR_I(ins),
		.FILE_DATA_I(fd),
		.BUSY_O(busy),
		.SQUASH_O(squash),
		.ZERO_FLAG_O(zf),
		.ZERO_WE_O(zwe),
		.FILE_WR_O(fwr),
		.PROG_WR_O(pwr),
		.WORKING_REGISTER_O(wrk),
		.TABLE_LATCH_O(lat),
		.TABLE_POINTER_O(ptr)
	);

	// Counts, verdict, end of run
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	// Case equality, so an unknown never matches
	task chk(input logic [40:0] got, input logic [40:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One word offered for one edge, taken or refused; valid stays high so back-to-back calls never toggle it
	task go(input logic [15:0] i, input logic [7:0] f);
		vld = 1'b1;
		ins = i;
		fd = f;
		@(posedge clk);
		#1;
	endtask : go

	// Let one more edge pass
	task step;
		vld = 1'b0;
		@(posedge clk);
		#1;
	endtask : step

	// Hang guard, far beyond the few dozen cycles of the tests
	initial begin
		#2000;
		fails++;
		final_report;
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		// Latch moves, spare bit both ways, top address
		go(16'hA5FF, 8'hB7);
		chk(lat, 41'h00B7);
		chk(fwr.en, 41'h0);
		go(16'hA600, 8'h53);
		chk(lat, 41'h53B7);
		go(16'hA210, 8'h00);
		chk(fwr, {1'b1, 8'h10, 8'h53});
		chk({lat, zwe}, {16'h53B7, 1'b0});
		go(16'hA120, 8'h00);
		chk(fwr, {1'b1, 8'h20, 8'hB7});
		$display("latch move test done");
		// Xor literal and register, both destinations
		go(16'hB4B5, 8'h00);
		chk({wrk, zf, zwe}, {8'hB5, 2'b01});
		go(16'hB4B5, 8'h00);
		chk({wrk, zf, zwe}, {8'h00, 2'b11});
		go(16'hB4B5, 8'h00);
		go(16'h0D07, 8'hAF);
		chk(fwr, {1'b1, 8'h07, 8'h1A});
		chk(wrk, 41'hB5);
		go(16'h0C06, 8'hB5);
		chk({wrk, zf, zwe}, {8'h00, 2'b11});
		$display("xor test done");
		// Skip not taken, then taken with a refused follower
		go(16'h3344, 8'h01);
		chk({squash, busy, zwe}, 41'h0);
		go(16'h3345, 8'h00);
		chk({squash, busy, zwe}, 41'h6);
		go(16'hB4FF, 8'h00);
		chk({squash, busy, wrk}, 41'h0);
		step;
		chk(wrk, 41'h00);
		$display("skip test done");
		// Table write high with increment, then low without; a refused
		// word with the other bit 8 sits in each store slot
		go(16'hAF33, 8'hAA);
		chk({lat, busy}, {16'hAAB7, 1'b1});
		go(16'hB40F, 8'h00);
		chk(pwr, {1'b1, 16'h0000, 16'hAAB7});
		chk({ptr, wrk}, {16'h0001, 8'h00});
		go(16'hAC44, 8'h53);
		chk(lat, 41'hAA53);
		go(16'hA5FF, 8'h11);
		chk(pwr, {1'b1, 16'h0001, 16'hAA53});
		chk({ptr, lat}, {16'h0001, 16'hAA53});
		$display("table write test done");
		final_report;
	end
endmodule : tlsx_exec_tb_top

// File: hw/tlsx_decode.sv
// Opcode decoder for the table-latch / skip / xor execution block.
// Assumes the instruction word is stable while its cycle executes.
`timescale 1ns/1ps
module tlsx_decode (
	// Instruction
	input wire logic [15:0] instr_i,
	// Decoded strobes
	output logic is_lrd_o,
	output logic is_lwt_o,
	output logic is_twr_o,
	output logic is_tst_o,
	output logic is_xlit_o,
	output logic is_xreg_o
);
	// Spare bit 8 of latch moves is never examined
	always_comb begin
		is_lrd_o = instr_i[15:10] == tlsx_pkg::OP_LATCH_READ;
		is_lwt_o = instr_i[15:10] == tlsx_pkg::OP_LATCH_WRITE;
		is_twr_o = instr_i[15:10] == tlsx_pkg::OP_TABLE_WRITE;
		is_tst_o = instr_i[15:8] == tlsx_pkg::OP_TEST_SKIP;
		is_xlit_o = instr_i[15:8] == tlsx_pkg::OP_XOR_LIT;
		is_xreg_o = instr_i[15:9] == tlsx_pkg::OP_XOR_REG;
	end
endmodule : tlsx_decode

// File: hw/tlsx_exec.sv
// Execution unit for latch moves, table write, test-skip and xor.
// Assumes the core presents one instruction per cycle with its file
// operand already read, and commits the requested writes itself.
`timescale 1ns/1ps
module tlsx_exec (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// Instruction in
	input wire logic INSTR_VALID_I,
	input wire logic [15:0] INSTR_I,
	input wire logic [7:0] FILE_DATA_I,
	// Execution status
	output logic BUSY_O,
	output logic SQUASH_O,
	output logic ZERO_FLAG_O,
	output logic ZERO_WE_O,
	// Result writes
	output tlsx_pkg::tlsx_fwr_t FILE_WR_O,
	output tlsx_pkg::tlsx_pwr_t PROG_WR_O,
	// Architectural state
	output logic [7:0] WORKING_REGISTER_O,
	output logic [15:0] TABLE_LATCH_O,
	output logic [15:0] TABLE_POINTER_O
);
	logic is_lrd, is_lwt, is_twr, is_tst, is_xlit, is_xreg;
	logic take;
	logic sel, opt;
	logic [7:0] faddr, xres;
	tlsx_pkg::tlsx_state_t state_r, state_nxt;
	logic [7:0] lat_hi_r, lat_hi_nxt, lat_lo_r, lat_lo_nxt;
	logic [7:0] work_r, work_nxt;
	logic busy_r, busy_nxt, inc_r, inc_nxt;
	logic [15:0] ptr_r, ptr_nxt;
	logic zf_r, zf_nxt, zwe_r, zwe_nxt, sq_r, sq_nxt;
	tlsx_pkg::tlsx_fwr_t fwr_r, fwr_nxt;
	tlsx_pkg::tlsx_pwr_t pwr_r, pwr_nxt;

	tlsx_decode tlsx_decode_inst (
		.instr_i(INSTR_I),
		.is_lrd_o(is_lrd),
		.is_lwt_o(is_lwt),
		.is_twr_o(is_twr),
		.is_tst_o(is_tst),
		.is_xlit_o(is_xlit),
		.is_xreg_o(is_xreg)
	);

	// Operand fields; address is a full byte
	assign sel = INSTR_I[tlsx_pkg::SEL_BIT];
	assign opt = INSTR_I[tlsx_pkg::OPT_BIT];
	assign faddr = INSTR_I[7:0];
	// Instructions in the squashed slot or store slot are not accepted
	assign take = INSTR_VALID_I && state_r == tlsx_pkg::TLSX_RUN;
	assign xres = work_r ^ (is_xlit ? INSTR_I[7:0] : FILE_DATA_I);

	// Next-state logic for every instruction of the group
	always_comb begin
		state_nxt = tlsx_pkg::TLSX_RUN;
		lat_hi_nxt = lat_hi_r;
		lat_lo_nxt = lat_lo_r;
		work_nxt = work_r;
		inc_nxt = inc_r;
		ptr_nxt = ptr_r;
		zf_nxt = zf_r;
		zwe_nxt = 1'b0;
		sq_nxt = 1'b0;
		fwr_nxt = '0;
		pwr_nxt = '0;
		case (state_r)
		tlsx_pkg::TLSX_RUN: begin
			if (take && is_lrd) begin
				// Latch untouched, flags untouched
				fwr_nxt.en = 1'b1;
				fwr_nxt.addr = faddr;
				fwr_nxt.data = sel ? lat_hi_r : lat_lo_r;
			end
			if (take && (is_lwt || is_twr)) begin
				// Only the selected half changes
				if (sel) begin
					lat_hi_nxt = FILE_DATA_I;
				end else begin
					lat_lo_nxt = FILE_DATA_I;
				end
			end
			if (take && is_twr) begin
				state_nxt = tlsx_pkg::TLSX_PWR;
				inc_nxt = opt;
			end
			if (take && is_tst && FILE_DATA_I == tlsx_pkg::BYTE_RST) begin
				state_nxt = tlsx_pkg::TLSX_SKIP;
				sq_nxt = 1'b1;
			end
			if (take && (is_xlit || (is_xreg && !opt))) begin
				work_nxt = xres;
			end
			if (take && is_xreg && opt) begin
				fwr_nxt.en = 1'b1;
				fwr_nxt.addr = faddr;
				fwr_nxt.data = xres;
			end
			if (take && (is_xlit || is_xreg)) begin
				zf_nxt = xres == tlsx_pkg::BYTE_RST;
				zwe_nxt = 1'b1;
			end
		end
		tlsx_pkg::TLSX_SKIP: begin
			// Prefetched word discarded, acts as a no-operation
			state_nxt = tlsx_pkg::TLSX_RUN;
		end
		tlsx_pkg::TLSX_PWR: begin
			// Whole latch, already holding the new byte, goes out
			pwr_nxt.en = 1'b1;
			pwr_nxt.addr = ptr_r;
			pwr_nxt.data = {lat_hi_r, lat_lo_r};
			// Option kept from the take; the word now on the bus is refused
			if (inc_r) begin
				ptr_nxt = ptr_r + tlsx_pkg::PTR_STEP;
			end
			state_nxt = tlsx_pkg::TLSX_RUN;
		end
		default: begin
			state_nxt = tlsx_pkg::TLSX_RUN;
		end
		endcase
		// Busy registered so the output comes from a flip-flop
		busy_nxt = state_nxt != tlsx_pkg::TLSX_RUN;
	end

	// Registers only
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_r <= tlsx_pkg::TLSX_RUN;
			lat_hi_r <= tlsx_pkg::BYTE_RST;
			lat_lo_r <= tlsx_pkg::BYTE_RST;
			work_r <= tlsx_pkg::BYTE_RST;
			busy_r <= 1'b0;
			inc_r <= 1'b0;
			ptr_r <= tlsx_pkg::PTR_RST;
			zf_r <= 1'b0;
			zwe_r <= 1'b0;
			sq_r <= 1'b0;
			fwr_r <= '0;
			pwr_r <= '0;
		end else begin
			state_r <= state_nxt;
			lat_hi_r <= lat_hi_nxt;
			lat_lo_r <= lat_lo_nxt;
			work_r <= work_nxt;
			busy_r <= busy_nxt;
			inc_r <= inc_nxt;
			ptr_r <= ptr_nxt;
			zf_r <= zf_nxt;
			zwe_r <= zwe_nxt;
			sq_r <= sq_nxt;
			fwr_r <= fwr_nxt;
			pwr_r <= pwr_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign BUSY_O = busy_r;
	assign SQUASH_O = sq_r;
	assign ZERO_FLAG_O = zf_r;
	assign ZERO_WE_O = zwe_r;
	assign FILE_WR_O = fwr_r;
	assign PROG_WR_O = pwr_r;
	assign WORKING_REGISTER_O = work_r;
	assign TABLE_LATCH_O = {lat_hi_r, lat_lo_r};
	assign TABLE_POINTER_O = ptr_r;

	// Checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	sequence s_lrd_hi;
		take && is_lrd && sel;
	endsequence
	property p_lrd_hi;
		s_lrd_hi |=> FILE_WR_O.en && FILE_WR_O.data == $past(lat_hi_r);
	endproperty
	a_lrd_hi: assert property (p_lrd_hi) else $error("latch read high");
	property p_lrd_keep;
		take && is_lrd |=> $stable(TABLE_LATCH_O) && !ZERO_WE_O;
	endproperty
	a_lrd_keep: assert property (p_lrd_keep) else $error("latch changed");
	property p_lrd_lo;
		take && is_lrd && !sel |=> FILE_WR_O.data == $past(lat_lo_r)
			&& FILE_WR_O.addr == $past(faddr);
	endproperty
	a_lrd_lo: assert property (p_lrd_lo) else $error("latch read low");
	property p_lwt;
		take && is_lwt && sel |=> TABLE_LATCH_O[15:8] == $past(FILE_DATA_I)
			&& TABLE_LATCH_O[7:0] == $past(lat_lo_r);
	endproperty
	a_lwt: assert property (p_lwt) else $error("latch write high");
	property p_lwt_lo;
		take && is_lwt && !sel |=> TABLE_LATCH_O[7:0] == $past(FILE_DATA_I)
			&& TABLE_LATCH_O[15:8] == $past(lat_hi_r);
	endproperty
	a_lwt_lo: assert property (p_lwt_lo) else $error("latch write low");
	sequence s_twr_inc;
		take && is_twr && sel && opt;
	endsequence
	property p_twr_inc;
		s_twr_inc |=> ##1 PROG_WR_O.en && PROG_WR_O.addr == $past(ptr_r, 2)
			&& TABLE_POINTER_O == $past(ptr_r, 2) + tlsx_pkg::PTR_STEP;
	endproperty
	a_twr_inc: assert property (p_twr_inc) else $error("store increment");
	property p_twr_keep;
		take && is_twr && !sel && !opt |=> ##1 PROG_WR_O.en
			&& PROG_WR_O.data[7:0] == $past(FILE_DATA_I, 2)
			&& TABLE_POINTER_O == $past(ptr_r, 2);
	endproperty
	a_twr_keep: assert property (p_twr_keep) else $error("store no inc");
	property p_skip;
		take && is_tst |=> SQUASH_O == ($past(FILE_DATA_I) == 8'h00)
			&& !ZERO_WE_O;
	endproperty
	a_skip: assert property (p_skip) else $error("test skip");
	property p_squash;
		SQUASH_O |-> BUSY_O ##1 !BUSY_O;
	endproperty
	a_squash: assert property (p_squash) else $error("skip length");
	property p_xlit;
		take && is_xlit |=> WORKING_REGISTER_O
			== ($past(work_r) ^ $past(INSTR_I[7:0]))
			&& ZERO_FLAG_O == (WORKING_REGISTER_O == 8'h00);
	endproperty
	a_xlit: assert property (p_xlit) else $error("xor literal");
	property p_xreg;
		take && is_xreg && opt |=> FILE_WR_O.en
			&& $stable(WORKING_REGISTER_O);
	endproperty
	a_xreg: assert property (p_xreg) else $error("xor register");
endmodule : tlsx_exec

// File: hw/tlsx_pkg.sv
// Package for the table-latch / skip / xor execution block.
// Assumes a 16-bit instruction word and 8-bit file registers.
package tlsx_pkg;
	// Opcode fields
	localparam logic [5:0] OP_LATCH_READ = 6'h28; // 1010 00
	localparam logic [5:0] OP_LATCH_WRITE = 6'h29; // 1010 01
	localparam logic [5:0] OP_TABLE_WRITE = 6'h2B; // 1010 11
	localparam logic [7:0] OP_TEST_SKIP = 8'h33; // 0011 0011
	localparam logic [7:0] OP_XOR_LIT = 8'hB4; // 1011 0100
	localparam logic [6:0] OP_XOR_REG = 7'h06; // 0000 110
	// Bit positions inside the instruction word
	localparam int SEL_BIT = 9;
	localparam int OPT_BIT = 8;
	// Reset values, pointer step and no-op word
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [15:0] PTR_STEP = 16'h0001;
	localparam logic [15:0] INSTR_NOP = 16'h0000;

	// Execution sequencer states, Gray along the usual path
	typedef enum logic [1:0] {
		TLSX_RUN = 2'b00,
		TLSX_SKIP = 2'b01,
		TLSX_PWR = 2'b10
	} tlsx_state_t;

	// One file-register write request
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} tlsx_fwr_t;

	// One program-memory write request
	typedef struct packed {
		logic en;
		logic [15:0] addr;
		logic [15:0] data;
	} tlsx_pwr_t;
endpackage : tlsx_pkg
